// ==== rtl/asw_gen.sv ====
// Purpose: Gravity-style sine wave generator feeding an 8-bit PWM D/A stage.
// Assumes: 100 MHz clock; frequency step is synchronous to i_clk.
// Notes:   Samples pass through an 8-word FIFO; i_hold stalls the PWM loader.
`timescale 1ns/10ps
`default_nettype none
`include "asw_regs.svh"

// Contract
// - Every tick adds the 16-bit frequency step into the phase accumulator, wrapping.
// - A new sample is computed only after a tick on which the accumulator rolled over.
// - One output cycle is 32 successive sample updates.
// - Ticks come at a fixed 3.26 us period.
// - Output frequency is step times 0.14627 Hz, at most 9.6 kHz.
// - Velocity goes up when the wave is negative and down when it is positive.
// - The new velocity is added to the wave to form the next sample.
// - The PWM duty loaded is the new sample plus 128.
// - Each tick first services the PWM stage, then accumulates.
module asw_gen
    import asw_pkg::*;
#(
    parameter int FIFO_DEPTH = 8,
    parameter int TICK_CYC = `ASW_TICK_CYC
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Control
    input wire logic [15:0] i_frequency_step,
    input wire logic i_hold,
    // Outputs
    output logic o_pwm,
    output logic [7:0] o_duty,
    output logic o_tick,
    output logic o_cycle_start
);
    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    logic rst_meta_r;
    logic rst_n_r;

    // Two-stage release keeps the deassertion synchronous
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_meta_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r <= rst_meta_r;
        end
    end

    // ----------------------------------------
    // Core state
    // ----------------------------------------
    asw_state_t s_r;
    asw_state_t s_nxt;
    logic [16:0] acc_sum;
    logic carry;
    logic upd;
    asw_wave_t vel_new;
    asw_wave_t wave_new;
    asw_duty_t push_data;
    logic fifo_wr_ready;
    logic fifo_rd_valid;
    asw_duty_t fifo_rd_data;
    logic pop;

    // Last count of the tick divider
    localparam int TICK_LAST = TICK_CYC - 1;

    // Phase arithmetic and the gravity step
    always_comb begin
        // 16-bit wrap over 32 steps fixes the resolution per step unit
        acc_sum = {1'b0, s_r.phase_accumulator} + {1'b0, i_frequency_step};
        carry = s_r.tick && acc_sum[16];
        upd = s_r.pend && fifo_wr_ready;
        if (s_r.wave[7]) begin
            vel_new = s_r.vel + 8'sh01;
        end else if (s_r.wave != 8'sh00) begin
            vel_new = s_r.vel - 8'sh01;
        end else begin
            vel_new = s_r.vel;
        end
        wave_new = s_r.wave + vel_new;
        push_data = asw_duty_t'(wave_new) + `ASW_DUTY_OFFSET;
    end

    // Loader pops one sample per tick unless the outside holds it
    assign pop = s_r.tick && !i_hold && fifo_rd_valid;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.tick = 1'b0;
        s_nxt.cycle_start = 1'b0;
        // Tick divider; period is fixed so every frequency ratio holds
        if (s_r.tick_cnt == 9'(TICK_LAST)) begin
            s_nxt.tick_cnt = '0;
            s_nxt.tick = 1'b1;
        end else begin
            s_nxt.tick_cnt = s_r.tick_cnt + 9'h001;
        end
        // PWM service comes first in the tick
        if (pop) begin
            s_nxt.duty = fifo_rd_data;
        end
        // Then the accumulation step
        if (s_r.tick) begin
            s_nxt.phase_accumulator = acc_sum[15:0];
        end
        // New sample; a fresh rollover wins over the clear of the pending flag
        if (upd) begin
            s_nxt.vel = vel_new;
            s_nxt.wave = wave_new;
            s_nxt.step_idx = s_r.step_idx + 5'h01;
            s_nxt.cycle_start = (s_r.step_idx == 5'h1F);
        end
        s_nxt.pend = (s_r.pend && !upd) || carry;
        // Free-running compare stage
        s_nxt.pwm_cnt = s_r.pwm_cnt + 8'h01;
        s_nxt.pwm_out = (s_r.pwm_cnt < s_r.duty);
    end

    // Reset gives a swing to start from and no initial speed
    always_ff @(posedge i_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            s_r <= '0;
            s_r.wave <= `ASW_INIT_AMP;
            s_r.vel <= `ASW_INIT_VEL;
            s_r.duty <= `ASW_INIT_DUTY;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ----------------------------------------
    // Sample buffer
    // ----------------------------------------
    asw_fifo #(
        .W(8),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_clk(i_clk),
        .i_rst_n(rst_n_r),
        .i_wr_valid(upd),
        .i_wr_data(push_data),
        .o_wr_ready(fifo_wr_ready),
        .o_rd_valid(fifo_rd_valid),
        .o_rd_data(fifo_rd_data),
        .i_rd_ready(s_r.tick && !i_hold)
    );

    // Outputs straight from flops
    assign o_pwm = s_r.pwm_out;
    assign o_duty = s_r.duty;
    assign o_tick = s_r.tick;
    assign o_cycle_start = s_r.cycle_start;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!rst_n_r);

    a_acc_adds: assert property (
        s_r.tick |=> s_r.phase_accumulator ==
            16'($past(s_r.phase_accumulator) + $past(i_frequency_step)))
        else $error("accumulator did not add the step on a tick");

    a_acc_idle: assert property (
        !s_r.tick |=> $stable(s_r.phase_accumulator))
        else $error("accumulator moved without a tick");

    a_roll_pends: assert property (
        carry |=> s_r.pend)
        else $error("rollover did not request a sample");

    a_wave_cause: assert property (
        !$stable(s_r.wave) |-> $past(s_r.pend && fifo_wr_ready))
        else $error("wave changed without a rollover");

    a_cycle_wrap: assert property (
        upd && s_r.step_idx == 5'h1F |=> s_r.cycle_start && s_r.step_idx == 5'h00)
        else $error("cycle did not close after 32 updates");

    a_tick_space: assert property (
        s_r.tick |=> !s_r.tick [*8])
        else $error("ticks closer than the tick period");

    a_tick_count: assert property (
        s_r.tick |-> $past(s_r.tick_cnt) == 9'(TICK_LAST))
        else $error("tick did not end a full period");

    a_vel_up: assert property (
        upd && s_r.wave < 0 |=> s_r.vel == $past(s_r.vel) + 8'sh01)
        else $error("velocity not raised for negative wave");

    a_vel_down: assert property (
        upd && s_r.wave > 0 |=> s_r.vel == $past(s_r.vel) - 8'sh01)
        else $error("velocity not lowered for positive wave");

    a_wave_step: assert property (
        upd |=> s_r.wave == $past(s_r.wave) + s_r.vel)
        else $error("wave did not advance by the velocity");

    a_duty_offset: assert property (
        upd |=> ($past(push_data) ^ 8'h80) == asw_duty_t'(s_r.wave))
        else $error("pushed duty is not sample plus 128");

    a_duty_load: assert property (
        pop |=> s_r.duty == $past(fifo_rd_data))
        else $error("tick did not load the buffered duty");

    a_duty_hold: assert property (
        !pop |=> $stable(s_r.duty))
        else $error("duty changed without a loading tick");

    a_pwm_low: assert property (
        s_r.pwm_cnt >= s_r.duty |=> !o_pwm)
        else $error("pwm high with counter at or above duty");

    a_pwm_cmp: assert property (
        s_r.pwm_cnt == 8'h00 && s_r.duty != 8'h00 |=> o_pwm)
        else $error("pwm low at counter start with nonzero duty");
endmodule
`default_nettype wire

// ==== shared/asw_regs.svh ====
// Purpose: Constants of the artificial sine wave generator.
// Assumes: A 100 MHz core clock.
// Notes:   Definitions only; guarded against double inclusion.
`ifndef ASW_REGS_SVH
`define ASW_REGS_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define ASW_CLK_PERIOD_NS 10
`define ASW_TICK_NS 3260
`define ASW_TICK_CYC (`ASW_TICK_NS / `ASW_CLK_PERIOD_NS)
`define ASW_TICK_W 9

// ----------------------------------------
// Output frequency figures: resolution in uHz, ceiling in Hz
// ----------------------------------------
`define ASW_RES_UHZ 146270
`define ASW_FMAX_HZ 9600

// ----------------------------------------
// Wave shape
// ----------------------------------------
`define ASW_STEPS_PER_CYCLE 32
`define ASW_STEP_IDX_W 5
`define ASW_DUTY_OFFSET 8'h80
`define ASW_INIT_AMP 8'h24
`define ASW_INIT_VEL 8'h00
`define ASW_INIT_DUTY 8'h80

`endif

// ==== shared/asw_pkg.sv ====
// Purpose: Types shared by the sine wave generator design files.
// Assumes: Nothing beyond SystemVerilog packed types.
// Notes:   Constants live in asw_regs.svh.
package asw_pkg;
    typedef logic [15:0] asw_phase_t;
    typedef logic [7:0] asw_duty_t;
    typedef logic signed [7:0] asw_wave_t;

    // State of the generator core
    typedef struct packed {
        logic [8:0] tick_cnt;
        logic tick;
        asw_phase_t phase_accumulator;
        logic pend;
        asw_wave_t wave;
        asw_wave_t vel;
        logic [4:0] step_idx;
        logic cycle_start;
        asw_duty_t duty;
        asw_duty_t pwm_cnt;
        logic pwm_out;
    } asw_state_t;
endpackage

// ==== rtl/asw_fifo.sv ====
// Purpose: Small sample FIFO between wave generation and the PWM loader.
// Assumes: Single clock, asynchronous active-low reset released synchronously upstream.
// Notes:   Read data come from the storage registers at the read pointer.
`timescale 1ns/10ps
`default_nettype none
module asw_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Write side
    input wire logic i_wr_valid,
    input wire logic [W-1:0] i_wr_data,
    output logic o_wr_ready,
    // Read side
    output logic o_rd_valid,
    output logic [W-1:0] o_rd_data,
    input wire logic i_rd_ready
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [AW:0] count;
    } fifo_state_t;

    fifo_state_t s_r;
    fifo_state_t s_nxt;
    logic push;
    logic pop;

    // ----------------------------------------
    // Handshakes
    // ----------------------------------------
    assign o_wr_ready = (s_r.count != (AW+1)'(DEPTH));
    assign o_rd_valid = (s_r.count != '0);
    assign o_rd_data = s_r.mem[s_r.rd_ptr];
    assign push = i_wr_valid && o_wr_ready;
    assign pop = i_rd_ready && o_rd_valid;

    // Pointer and storage update; pointers wrap at DEPTH-1 for any depth
    always_comb begin
        s_nxt = s_r;
        if (push) begin
            s_nxt.mem[s_r.wr_ptr] = i_wr_data;
            s_nxt.wr_ptr = (s_r.wr_ptr == AW'(DEPTH-1)) ? '0 : s_r.wr_ptr + 1'b1;
        end
        if (pop) begin
            s_nxt.rd_ptr = (s_r.rd_ptr == AW'(DEPTH-1)) ? '0 : s_r.rd_ptr + 1'b1;
        end
        s_nxt.count = s_r.count + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule
`default_nettype wire

// ==== tb/asw_rc_model.sv ====
// Purpose: Behavioural RC low-pass filter seen by the PWM output pin.
// Assumes: One clock; level scaled so full scale is 255 * 256.
// Notes:   First-order IIR; ripple is large, so callers average it.
`timescale 1ns/10ps
`default_nettype none
module asw_rc_model (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Filter input and output
    input wire logic i_pwm,
    output logic [15:0] o_level
);
    int lvl;
    // ----------------------------------------
    // Filter
    // ----------------------------------------
    // Integer step; truncation bias stays well under one duty step
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            lvl <= 0;
        end else begin
            lvl <= lvl + ((i_pwm ? 65280 : 0) - lvl) / 32;
        end
    end
    assign o_level = 16'(lvl);
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// Purpose: Self-checking bench of the sine wave generator.
// Assumes: Short tick period for speed; queue mirrors the sample FIFO.
// Notes:   Predictor pushes expected duties, watcher pops on loading ticks.
`timescale 1ns/10ps
`default_nettype none
`include "asw_regs.svh"
module tb;
    import asw_pkg::*;
    localparam int TICK = 16;
    logic i_clk = 1'b0, i_rst_n = 1'b0, i_hold = 1'b0;
    logic [15:0] i_frequency_step = 16'h0000;
    logic o_pwm, o_tick, o_cycle_start;
    logic [7:0] o_duty;
    logic [15:0] level;
    asw_duty_t q[$];
    asw_duty_t last_exp = `ASW_INIT_DUTY;
    asw_wave_t wave = `ASW_INIT_AMP, vel = `ASW_INIT_VEL;
    logic [15:0] acc = 16'h0000;
    logic [16:0] sum;
    logic pend = 1'b0, chk_nxt = 1'b0;
    logic [31:0] seed = 32'h2054C502;
    int bad_count = 0, total_checks = 0, upd = 0, cs = 0, gap = 0, highs, lsum;
    int ticks = 0, pulses = 0, tk = 0;
    always #5 i_clk = ~i_clk;
    asw_gen #(.FIFO_DEPTH(8), .TICK_CYC(TICK)) i_asw_gen (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_frequency_step(i_frequency_step), .i_hold(i_hold), .o_pwm(o_pwm),
        .o_duty(o_duty), .o_tick(o_tick), .o_cycle_start(o_cycle_start));
    asw_rc_model i_asw_rc_model (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_pwm(o_pwm),
        .o_level(level));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        if (bad_count == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    // ----------------------------------------
    // Predictor: accumulator, pending flag, gravity step
    // ----------------------------------------
    // Push only off tick cycles, so it never races the watcher's pop
    always @(negedge i_clk) begin
        if (i_rst_n && o_tick === 1'b1) begin
            sum = {1'b0, acc} + {1'b0, i_frequency_step};
            acc = sum[15:0];
            if (sum[16]) pend = 1'b1;
        end else if (pend && q.size() < 8) begin
            if (wave < 0) vel = vel + 8'sh01;
            else if (wave > 0) vel = vel - 8'sh01;
            wave = wave + vel;
            q.push_back(8'(wave) + `ASW_DUTY_OFFSET);
            pend = 1'b0; // merged rollovers give one sample
            upd++;
        end
    end
    // ----------------------------------------
    // Watcher: tick spacing, duty loads, cycle pulses
    // ----------------------------------------
    always @(negedge i_clk) begin
        if (chk_nxt) chk(o_duty, last_exp);
        chk_nxt = 1'b0;
        if (o_cycle_start === 1'b1) cs++;
        gap++;
        if (o_tick === 1'b1) begin
            if (ticks > 0) chk(gap, TICK);
            ticks++;
            gap = 0;
            if (!i_hold && q.size() > 0) begin
                last_exp = q.pop_front();
                chk_nxt = 1'b1;
            end
        end
    end
    // ----------------------------------------
    // Stimulus
    // ----------------------------------------
    initial begin
        repeat (10) @(negedge i_clk);
        chk(o_duty, `ASW_INIT_DUTY);
        repeat (10) @(negedge i_clk);
        i_rst_n = 1'b1;
        // Random steps, top bit set so rollovers are frequent
        repeat (300) begin
            seed = xs(seed);
            i_frequency_step = seed[15:0] | 16'h8000;
            repeat (TICK) @(negedge i_clk);
        end
        // Zero step: no new samples, queue drains
        i_frequency_step = 16'h0000;
        repeat (20 * TICK) @(negedge i_clk);
        // Stall the loader with max step: FIFO fills, rollovers merge
        i_hold = 1'b1;
        i_frequency_step = 16'hFFFF;
        repeat (14 * TICK) @(negedge i_clk);
        chk(q.size(), 8);
        highs = 0;
        lsum = 0;
        repeat (256) begin
            @(negedge i_clk);
            highs += (o_pwm === 1'b1);
            lsum += level;
        end
        chk(highs, last_exp);
        chk((lsum / 256 / 255 + 3 - last_exp) < 7, 1);
        i_hold = 1'b0;
        i_frequency_step = 16'h0000;
        repeat (14 * TICK) @(negedge i_clk);
        chk(q.size(), 0);
        chk(cs, upd / 32);
        // Fixed step: ticks per output cycle follow from the step alone
        i_frequency_step = 16'h4000;
        repeat (300 * TICK) begin
            @(negedge i_clk);
            if (pulses == 1 && o_tick === 1'b1) tk++;
            if (o_cycle_start === 1'b1) pulses++;
            if (pulses == 2) break;
        end
        chk(tk, `ASW_STEPS_PER_CYCLE * 32'h10000 / 32'h4000);
        print_verdict();
    end
    // Watchdog against a hang
    initial begin
        #900000;
        bad_count++;
        print_verdict();
    end
endmodule
`default_nettype wire
